/* File: fpec_core_model.sv */
// Core model issuing data-move requests
`timescale 1ns/10ps
module fpec_core_model (
  input wire logic core_clk,
  input wire logic core_stall,
  output fpec_pkg::fpec_req_s xdm_req
);
  initial xdm_req = '0;
  // One-cycle pulse; held back while the core is stalled
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk);
    while (core_stall)
      @(negedge core_clk);
    xdm_req = '{w, !w, a, d};
    @(negedge core_clk);
    // Released bus shows inverted leftovers, never a stale match
    xdm_req = '{1'b0, 1'b0, ~a, ~d};
  endtask : xfer
endmodule : fpec_core_model

/* File: fpec_pkg.sv */
// Constants and carrier types for the flash program/erase controller
package fpec_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int FLASH_BYTES = 65536;
  localparam int PAGE_BYTES = 512;
  localparam int PAGE_W = 9;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] ALL_ZERO_BYTE = 8'h00;
  localparam int IRQ_N = 20;
  // Timing, figures in their own units, counts derived from the clock
  localparam int CLK_PERIOD_NS = 8;
  localparam int WRITE_TIME_NS = 50000;
  localparam int ERASE_TIME_US = 12000;
  localparam int NS_PER_US = 1000;
  localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES =
    (ERASE_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Control bit reset values
  localparam logic REDIRECT_RST = 1'b0;
  localparam logic ERASE_EN_RST = 1'b0;
  localparam logic WRITE_EN_RST = 1'b0;

  typedef enum logic [1:0]
  {
    FPEC_IDLE = 2'b00,
    FPEC_PROG = 2'b01,
    FPEC_ERASE = 2'b10
  } fpec_state_e;

  // Data-move request from the core or byte request from the test port
  typedef struct packed
  {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fpec_req_s;

  // Control bits held by the controller
  typedef struct packed
  {
    logic store_write_redirect;
    logic page_erase_enable;
    logic soft_flash_write_enable;
  } fpec_ctl_s;
endpackage : fpec_pkg

/* File: fpec_tb_top.sv */
// Self-checking bench for the flash program/erase controller
`timescale 1ns/10ps
module fpec_tb_top;
  localparam int WC = 4;
  localparam int EC = 600;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic ps_wr = 1'b0;
  logic pinit = 1'b1;
  logic [15:0] caddr = '0;
  logic [19:0] irq_in = '0;
  fpec_pkg::fpec_ctl_s wd = '0;
  fpec_pkg::fpec_ctl_s cs;
  fpec_pkg::fpec_req_s xdm, external_data_ram;
  fpec_pkg::fpec_req_s tap = '0;
  logic [7:0] cdata;
  logic stall;
  logic [19:0] irq_out;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  always #4 core_clk = ~core_clk;
  fpec_top #(.WRITE_CYC(WC), .ERASE_CYC(EC)) fpec_top_inst (.core_clk(core_clk), .rstn(rstn),
    .ce(ce), .program_store_control_wr(ps_wr), .flash_scale_control_wr(ps_wr),
    .ctl_wdata(wd), .ctl_state(cs), .xdm_req(xdm), .external_data_ram_req(external_data_ram), .tap_req(tap),
    .part_initialized(pinit), .code_addr(caddr), .code_data(cdata), .core_stall(stall),
    .irq_in(irq_in), .irq_out(irq_out));
  fpec_core_model fpec_core_model_inst (.core_clk(core_clk), .core_stall(stall),
    .xdm_req(xdm));
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    num_checks++;
    if (got !== exp)
      $display("ERROR %0t got %0h want %0h", $time, got, exp);
    if (got !== exp)
      bad_count++;
  endtask : chk
  // Both control strobes together load all three bits
  task automatic ctl(input logic [2:0] v);
    @(negedge core_clk);
    wd = v;
    ps_wr = 1'b1;
    @(negedge core_clk);
    ps_wr = 1'b0;
  endtask : ctl
  // Data-move write, then count stalled cycles
  task automatic op(input logic [15:0] a, input logic [7:0] d, input int exp);
    int n;
    n = 0;
    fpec_core_model_inst.xfer(1'b1, a, d);
    while (stall === 1'b1 && n < 2000)
    begin
      n++;
      @(negedge core_clk);
    end
    chk(n, exp);
  endtask : op
  task automatic code(input logic [15:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    caddr = a;
    @(negedge core_clk);
    chk(cdata, exp);
  endtask : code
  // Redirect clear sends writes out; reads go out even when set
  task automatic t_route();
    ctl(3'b001);
    fpec_core_model_inst.xfer(1'b1, 16'h1234, 8'h3c);
    chk({external_data_ram.wr, external_data_ram.data, stall}, {1'b1, 8'h3c, 1'b0});
    ctl(3'b101);
    fpec_core_model_inst.xfer(1'b0, 16'h0042, 8'h00);
    chk({external_data_ram.rd, external_data_ram.addr}, {1'b1, 16'h0042});
  endtask : t_route
  // Missing write enable, then missing init strap: write dropped
  task automatic t_refuse();
    ctl(3'b100);
    op(16'h0100, 8'h00, 0);
    ctl(3'b101);
    pinit = 1'b0;
    repeat (3) @(negedge core_clk);
    op(16'h0100, 8'h00, 0);
    pinit = 1'b1;
    repeat (3) @(negedge core_clk);
  endtask : t_refuse
  // Page erase, then program and reprogram one byte; addresses kept low
  task automatic t_flash();
    ctl(3'b111);
    op(16'h0321, 8'h00, EC);
    code(16'h0200, 8'hff);
    code(16'h03ff, 8'hff);
    ctl(3'b101);
    op(16'h0210, 8'h5a, WC);
    code(16'h0210, 8'h5a);
    op(16'h0210, 8'ha5, WC);
    code(16'h0210, 8'h00);
    chk(cs, 3'b101);
  endtask : t_flash
  // Interrupt in mid-write is held, then shown once idle
  task automatic t_irq();
    fpec_core_model_inst.xfer(1'b1, 16'h0222, 8'h77);
    irq_in = 20'h00008;
    @(negedge core_clk);
    irq_in = '0;
    chk(irq_out, 0);
    while (stall === 1'b1)
      @(negedge core_clk);
    chk(irq_out, 20'h00008);
  endtask : t_irq
  // Test port programs with every software enable clear
  task automatic t_tap();
    ctl(3'b000);
    tap = '{1'b1, 1'b0, 16'h0230, 8'h81};
    @(negedge core_clk);
    tap = '{1'b0, 1'b0, 16'hfdcf, 8'h7e};
    chk(stall, 1);
    repeat (WC) @(negedge core_clk);
    code(16'h0230, 8'h81);
  endtask : t_tap
  // Clock enable low in mid-write freezes the timer and the array
  task automatic t_freeze();
    int n;
    n = 0;
    tap = '{1'b1, 1'b0, 16'h0240, 8'h3c};
    @(negedge core_clk);
    tap = '{1'b0, 1'b0, 16'hfdbf, 8'hc3};
    ce = 1'b0;
    repeat (5) @(negedge core_clk);
    chk(stall, 1);
    ce = 1'b1;
    while (stall === 1'b1 && n < 2000)
    begin
      n++;
      @(negedge core_clk);
    end
    chk(n, WC);
    code(16'h0240, 8'h3c);
  endtask : t_freeze
  initial
  begin
    repeat (20) @(negedge core_clk);
    rstn = 1'b1;
    repeat (4) @(negedge core_clk);
    chk(cs, 3'b000);
    t_route();
    t_refuse();
    t_flash();
    t_irq();
    t_tap();
    t_freeze();
    give_verdict();
  end
  // Hang guard well above the expected run length
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
      bad_count++;
    if (cyc == 20000)
      give_verdict();
  end
endmodule : fpec_tb_top

/* File: fpec_timer.sv */
// Down counter that times one flash operation
`timescale 1ns/10ps
module fpec_timer #(
  parameter int CNT_W = 21
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic load,
  input wire logic [CNT_W-1:0] load_val,
  output logic expired
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;

  // Load wins; otherwise count down and park at zero
  always_comb
  begin
    next_cnt = cnt;
    if (load)
      next_cnt = load_val;
    else if (cnt != '0)
      next_cnt = cnt - CNT_W'(1);
  end

  // Last cycle of the timed interval
  assign expired = (cnt == CNT_W'(1));

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      cnt <= '0;
    else if (ce)
      cnt <= next_cnt;
  end
endmodule : fpec_timer

/* File: fpec_top.sv */
// Flash program/erase controller driven by the core's data-move bus
//
// Notes on behaviour
// - Flash is programmed a byte at a time, from test port or data-move write.
// - Programming only clears bits; setting bits back needs an erase.
// - Erase clears a whole 512-byte page to 0xFF.
// - Writes and erases are timed internally; no polling needed.
// - Core is stalled during write or erase; peripherals keep running.
// - Interrupts during an operation are held and released afterwards.
// - Redirect bit set sends data-move writes to flash, else to external RAM.
// - Redirect bit stays set until software clears it.
// - Data-move reads always go to external RAM; flash read via code-move.
// - Erase enable plus redirect makes a write erase its whole page.
// - Software writes and erases need the flash write enable bit.
// - A never-initialized part accepts programming only from the test port.
`timescale 1ns/10ps
module fpec_top #(
  parameter int WRITE_CYC = fpec_pkg::WRITE_CYCLES,
  parameter int ERASE_CYC = fpec_pkg::ERASE_CYCLES,
  parameter int FLASH_BYTES = fpec_pkg::FLASH_BYTES,
  parameter int IRQ_N = fpec_pkg::IRQ_N
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic program_store_control_wr,
  input wire logic flash_scale_control_wr,
  input wire fpec_pkg::fpec_ctl_s ctl_wdata,
  output fpec_pkg::fpec_ctl_s ctl_state,
  input wire fpec_pkg::fpec_req_s xdm_req,
  output fpec_pkg::fpec_req_s external_data_ram_req,
  input wire fpec_pkg::fpec_req_s tap_req,
  input wire logic part_initialized,
  input wire logic [fpec_pkg::ADDR_W-1:0] code_addr,
  output logic [fpec_pkg::DATA_W-1:0] code_data,
  output logic core_stall,
  input wire logic [IRQ_N-1:0] irq_in,
  output logic [IRQ_N-1:0] irq_out
);
  localparam int TMR_W = $clog2(ERASE_CYC + 1);
  localparam int AW = fpec_pkg::ADDR_W;
  localparam int DW = fpec_pkg::DATA_W;
  localparam int PW = fpec_pkg::PAGE_W;

  // Refuse sizes the sweep or the address space cannot serve
  initial
  begin
    if (WRITE_CYC < 1 || ERASE_CYC <= fpec_pkg::PAGE_BYTES || WRITE_CYC > ERASE_CYC)
      $error("fpec_top: write/erase cycle counts out of range");
    if (FLASH_BYTES % fpec_pkg::PAGE_BYTES != 0 || FLASH_BYTES > (1 << AW))
      $error("fpec_top: flash size must be whole pages within the address space");
  end

  logic [DW-1:0] flash_mem [FLASH_BYTES];

  fpec_pkg::fpec_state_e state;
  fpec_pkg::fpec_state_e next_state;
  fpec_pkg::fpec_ctl_s ctl;
  fpec_pkg::fpec_ctl_s next_ctl;
  logic [AW-1:0] op_addr;
  logic [AW-1:0] next_op_addr;
  logic [DW-1:0] op_data;
  logic [DW-1:0] next_op_data;
  logic [PW:0] sweep;
  logic [PW:0] next_sweep;
  logic [IRQ_N-1:0] irq_held;
  logic [IRQ_N-1:0] next_irq_held;
  fpec_pkg::fpec_req_s next_external_data_ram_req;
  logic [DW-1:0] next_code_data;
  logic init_meta;
  logic init_sync;

  logic busy;
  logic sw_flash_wr;
  logic sw_allowed;
  logic start_erase;
  logic start_prog;
  logic tmr_load;
  logic [TMR_W-1:0] tmr_val;
  logic tmr_expired;
  logic mem_we;
  logic [AW-1:0] mem_wa;
  logic [DW-1:0] mem_wd;

  // Page base of an address, used for the erase sweep
  function automatic logic [AW-1:0] page_base(input logic [AW-1:0] a);
    page_base = {a[AW-1:PW], {PW{1'b0}}};
  endfunction : page_base

  fpec_timer #(
    .CNT_W(TMR_W)
  ) u_timer (
    .core_clk(core_clk),
    .rstn(rstn),
    .ce(ce),
    .load(tmr_load),
    .load_val(tmr_val),
    .expired(tmr_expired)
  );

  // Request decode; the core has priority over the test port
  always_comb
  begin
    busy = (state != fpec_pkg::FPEC_IDLE);
    sw_flash_wr = xdm_req.wr && ctl.store_write_redirect;
    sw_allowed = ctl.soft_flash_write_enable && init_sync;
    start_erase = !busy && sw_flash_wr && sw_allowed && ctl.page_erase_enable;
    start_prog = !busy && ((sw_flash_wr && sw_allowed && !ctl.page_erase_enable)
                 || (!sw_flash_wr && tap_req.wr));
    tmr_load = start_erase || start_prog;
    tmr_val = start_erase ? TMR_W'(ERASE_CYC) : TMR_W'(WRITE_CYC);
  end

  // Operation sequencer and flash array write port
  always_comb
  begin
    next_state = state;
    next_op_addr = op_addr;
    next_op_data = op_data;
    next_sweep = sweep;
    mem_we = 1'b0;
    mem_wa = op_addr;
    mem_wd = fpec_pkg::ERASED_BYTE;
    case (state)
      fpec_pkg::FPEC_IDLE:
      begin
        next_sweep = '0;
        if (start_erase)
        begin
          next_state = fpec_pkg::FPEC_ERASE;
          next_op_addr = page_base(xdm_req.addr);
        end
        else if (start_prog)
        begin
          next_state = fpec_pkg::FPEC_PROG;
          next_op_addr = sw_flash_wr ? xdm_req.addr : tap_req.addr;
          next_op_data = sw_flash_wr ? xdm_req.data : tap_req.data;
        end
      end
      fpec_pkg::FPEC_PROG:
      begin
        // Commit at the end of the timed interval
        if (tmr_expired)
        begin
          mem_we = 1'b1;
          mem_wd = flash_mem[op_addr] & op_data;
          next_state = fpec_pkg::FPEC_IDLE;
        end
      end
      fpec_pkg::FPEC_ERASE:
      begin
        // One byte per cycle; the sweep is far shorter than the erase time
        if (!sweep[PW])
        begin
          mem_we = 1'b1;
          mem_wa = op_addr | AW'(sweep[PW-1:0]);
          next_sweep = sweep + (PW+1)'(1);
        end
        if (tmr_expired)
          next_state = fpec_pkg::FPEC_IDLE;
      end
      default:
        next_state = fpec_pkg::FPEC_IDLE;
    endcase
  end

  // Control bits: each bit changes only on its own register write
  always_comb
  begin
    next_ctl = ctl;
    if (program_store_control_wr)
    begin
      next_ctl.store_write_redirect = ctl_wdata.store_write_redirect;
      next_ctl.page_erase_enable = ctl_wdata.page_erase_enable;
    end
    if (flash_scale_control_wr)
      next_ctl.soft_flash_write_enable = ctl_wdata.soft_flash_write_enable;
  end

  // External RAM path, interrupt holding and code-move read
  always_comb
  begin
    next_external_data_ram_req = xdm_req;
    next_external_data_ram_req.wr = xdm_req.wr && !ctl.store_write_redirect;
    next_external_data_ram_req.rd = xdm_req.rd;
    next_irq_held = busy ? (irq_held | irq_in) : '0;
    next_code_data = flash_mem[code_addr];
  end

  // Stall and interrupt release follow the state register
  assign core_stall = busy;
  assign irq_out = busy ? '0 : (irq_in | irq_held);
  assign ctl_state = ctl;

  // Initialization strap comes from a pin; two flops before use
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      init_meta <= 1'b0;
      init_sync <= 1'b0;
    end
    else if (ce)
    begin
      init_meta <= part_initialized;
      init_sync <= init_meta;
    end
  end

  // Register the next values
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= fpec_pkg::FPEC_IDLE;
      ctl <= '{store_write_redirect: fpec_pkg::REDIRECT_RST,
               page_erase_enable: fpec_pkg::ERASE_EN_RST,
               soft_flash_write_enable: fpec_pkg::WRITE_EN_RST};
      op_addr <= '0;
      op_data <= '0;
      sweep <= '0;
      irq_held <= '0;
      external_data_ram_req <= '0;
      code_data <= fpec_pkg::ALL_ZERO_BYTE;
    end
    else if (ce)
    begin
      state <= next_state;
      ctl <= next_ctl;
      op_addr <= next_op_addr;
      op_data <= next_op_data;
      sweep <= next_sweep;
      irq_held <= next_irq_held;
      external_data_ram_req <= next_external_data_ram_req;
      code_data <= next_code_data;
    end
  end

  // Flash array has no reset; contents persist like the real cells
  always_ff @(posedge core_clk)
  begin
    if (ce && mem_we)
      flash_mem[mem_wa] <= mem_wd;
  end
endmodule : fpec_top

/* File: fpec_top_properties.sv */
// Port checks for the flash program/erase controller
`timescale 1ns/10ps
module fpec_props #(
  parameter int WRITE_CYC = 4,
  parameter int ERASE_CYC = 600
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic program_store_control_wr,
  input wire fpec_pkg::fpec_ctl_s ctl_state,
  input wire fpec_pkg::fpec_req_s xdm_req,
  input wire fpec_pkg::fpec_req_s external_data_ram_req,
  input wire logic part_initialized,
  input wire logic core_stall,
  input wire logic [fpec_pkg::IRQ_N-1:0] irq_in,
  input wire logic [fpec_pkg::IRQ_N-1:0] irq_out
);
  logic [20:0] len;
  logic [2:0] pi;
  logic rd;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  assign rd = ctl_state.store_write_redirect;
  // Stall length and strap history; both freeze with the clock enable
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      len <= '0;
      pi <= '0;
    end
    else if (ce)
    begin
      len <= core_stall ? len + 21'h1 : '0;
      pi <= {pi[1:0], part_initialized};
    end
  stall_start_a: assert property (xdm_req.wr && !core_stall && rd && &pi &&
    ctl_state.soft_flash_write_enable |=> core_stall) else $error("no stall");
  stall_len_a: assert property ($fell(core_stall) |->
    len == WRITE_CYC || len == ERASE_CYC) else $error("stall length");
  no_enable_a: assert property (xdm_req.wr && rd &&
    !ctl_state.soft_flash_write_enable && !core_stall |=> !core_stall) else $error("stall");
  external_data_ram_wr_a: assert property (xdm_req.wr && !core_stall && !rd |=> external_data_ram_req.wr &&
    external_data_ram_req.addr == $past(xdm_req.addr)) else $error("external_data_ram write");
  flash_wr_a: assert property (xdm_req.wr && rd |=> !external_data_ram_req.wr) else $error("leak");
  external_data_ram_rd_a: assert property (xdm_req.rd |=> external_data_ram_req.rd) else $error("external_data_ram read");
  irq_hold_a: assert property (core_stall |-> irq_out == '0) else $error("irq");
  irq_pass_a: assert property (!core_stall && !$past(core_stall) |->
    irq_out == irq_in) else $error("irq pass");
  redir_keep_a: assert property (rd && !program_store_control_wr |=> rd)
    else $error("redirect lost");
  cover property ($fell(core_stall) && len == ERASE_CYC);
  cover property ($fell(core_stall) && len == WRITE_CYC);
  cover property (core_stall && |irq_in);
  cover property (core_stall && !ce);
endmodule : fpec_props
bind fpec_top fpec_props #(.WRITE_CYC(WRITE_CYC), .ERASE_CYC(ERASE_CYC)) fpec_props_inst (
  .core_clk(core_clk), .rstn(rstn), .ce(ce),
  .program_store_control_wr(program_store_control_wr),
  .ctl_state(ctl_state), .xdm_req(xdm_req), .external_data_ram_req(external_data_ram_req),
  .part_initialized(part_initialized), .core_stall(core_stall), .irq_in(irq_in),
  .irq_out(irq_out));
